// >>> hw/converter_startup_config_regs.sv
// What this block does
// - slot codes 0 off, 1-5 timeslots
// - codes 6,7 follow hardware enables
// - converter 1 code: 0.6V-1.8V, 12.5mV steps
// - stored field is code bits 6:2
// - converter 1 floor below 09h, saturate from 68h
// - converter 4 code: 0.85V-3.4V, 25mV steps
// - converter 4 stored field, 100mV steps
// - converter 4 saturates from 66h
// - converter 3 code: 0.85V-3.4V, 25mV steps
// - converter 3 stored field, 100mV steps
// - converter 3 saturates from 66h
// - field layout of both registers
// - all fields reset to zero
// - converter 1 voltage at bits 4:0
// - converter 3 voltage at bits 4:0
// - converter 2 fields at 15:13, 12:8
// - converter 1 slot at bits 7:5
`timescale 1ns/1ps
module converter_startup_config_regs
   import conv_startup_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // hardware enable pins
   input  wire logic        hwEnable1Pin,
   input  wire logic        hwEnable2Pin,
   // converter outputs
   output logic      [3:0]  convEnable,
   output logic      [6:0]  conv1VoltCode,
   output logic      [6:0]  conv2VoltCode,
   output logic      [6:0]  conv3VoltCode,
   output logic      [6:0]  conv4VoltCode,
   output logic             fastModeViolation
);
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_STEP, SEQ_DONE} seq_state_t;

   logic [15:0] oneTwo_q, threeFour_q;
   logic        fastMode_q;
   logic        wrPend_q;
   logic [17:0] wrAddr_q;
   logic [31:0] rdData_q;
   logic [1:0]  hw1Sync_q, hw2Sync_q;
   seq_state_t  seq_q, seq_d;
   logic [2:0]  slot_q, slot_d;
   logic [31:0] cnt_q, cnt_d;
   logic [3:0]  en_q;
   logic [6:0]  code1_q, code2_q, code3_q, code4_q;
   logic        viol_q;

   // bus decode
   wire        addrPhase = hsel && hready && htrans[1];
   wire        wordAcc   = (hsize == 3'h2);
   wire [17:0] rdAddr    = haddr[17:0];
   wire        hiZero    = (haddr[31:18] == 14'h0000);
   wire        selOneTwo = hiZero && (rdAddr == ONE_TWO_ADDR);
   wire        selThree  = hiZero && (rdAddr == THREE_FOUR_ADDR);
   wire        selCtrl   = hiZero && (rdAddr == SEQ_CTRL_ADDR);
   wire        selStat   = hiZero && (rdAddr == SEQ_STAT_ADDR);
   wire        selVoltLo = hiZero && (rdAddr == VOLT_LOW_ADDR);
   wire        selVoltHi = hiZero && (rdAddr == VOLT_HIGH_ADDR);

   // write strobes, one per writable register, in the data phase
   wire        wrOneTwo  = wrPend_q && (wrAddr_q == ONE_TWO_ADDR);
   wire        wrThree   = wrPend_q && (wrAddr_q == THREE_FOUR_ADDR);
   wire        wrCtrl    = wrPend_q && (wrAddr_q == SEQ_CTRL_ADDR);
   wire        startReq  = wrCtrl && hwdata[0];

   // pins are asynchronous to mclk
   wire hwEn1 = hw1Sync_q[1];
   wire hwEn2 = hw2Sync_q[1];

   // field extraction
   wire [2:0] slot1   = oneTwo_q[LO_SLOT_LSB +: SLOT_W];
   wire [4:0] coarse1 = oneTwo_q[LO_VOLT_LSB +: COARSE_W];
   wire [2:0] slot2   = oneTwo_q[HI_SLOT_LSB +: SLOT_W];
   wire [4:0] coarse2 = oneTwo_q[HI_VOLT_LSB +: COARSE_W];
   wire [2:0] slot3   = threeFour_q[LO_SLOT_LSB +: SLOT_W];
   wire [4:0] coarse3 = threeFour_q[LO_VOLT_LSB +: COARSE_W];
   wire [2:0] slot4   = threeFour_q[HI_SLOT_LSB +: SLOT_W];
   wire [4:0] coarse4 = threeFour_q[HI_VOLT_LSB +: COARSE_W];
   wire [11:0] slots  = {slot4, slot3, slot2, slot1};

   // per-converter expansion results, converter 1 in the lowest slice
   wire [4*COARSE_W-1:0] coarses = {coarse4, coarse3, coarse2, coarse1};
   wire [4*CODE_W-1:0]   fulls;
   wire [4*VOLT_W-1:0]   volts;
   wire [CODE_W-1:0]     full1   = fulls[0*CODE_W +: CODE_W];
   wire [CODE_W-1:0]     full2   = fulls[1*CODE_W +: CODE_W];
   wire [CODE_W-1:0]     full3   = fulls[2*CODE_W +: CODE_W];
   wire [CODE_W-1:0]     full4   = fulls[3*CODE_W +: CODE_W];
   wire [3:0]            enNext;
   wire                  seqRun  = (seq_q != SEQ_IDLE);
   wire                  slotEnd = (cnt_q == 32'(SLOT_LEN - 1));
   wire                  seqDone = (seq_q == SEQ_DONE);

   // read words
   wire [31:0] oneTwoWord    = {16'h0000, oneTwo_q};
   wire [31:0] threeFourWord = {16'h0000, threeFour_q};
   wire [31:0] ctrlWord      = {30'h00000000, fastMode_q, 1'b0};
   wire [31:0] statWord      = {20'h00000, en_q, 1'b0, slot_q, 2'(seq_q), viol_q, seqDone};
   wire [31:0] voltLowWord   = volts[0 +: 32];
   wire [31:0] voltHighWord  = volts[32 +: 32];

   // read mux; unmapped offsets read as zero
   wire [31:0] rdMux = selOneTwo ? oneTwoWord :
                       selThree  ? threeFourWord :
                       selCtrl   ? ctrlWord :
                       selStat   ? statWord :
                       selVoltLo ? voltLowWord :
                       selVoltHi ? voltHighWord :
                       32'h00000000;

   // sequencer next state
   always_comb begin
      seq_d  = seq_q;
      slot_d = slot_q;
      cnt_d  = cnt_q;
      unique case (seq_q)
         SEQ_IDLE: begin
            if (startReq) begin
               seq_d  = SEQ_STEP;
               slot_d = 3'h1;
               cnt_d  = 32'h00000000;
            end
         end
         SEQ_STEP: begin
            if (slotEnd) begin
               cnt_d = 32'h00000000;
               if (slot_q == 3'(NUM_SLOTS)) begin
                  seq_d = SEQ_DONE;
               end else begin
                  slot_d = slot_q + 3'h1;
               end
            end else begin
               cnt_d = cnt_q + 32'h00000001;
            end
         end
         SEQ_DONE: begin
            if (startReq) begin
               seq_d  = SEQ_STEP;
               slot_d = 3'h1;
               cnt_d  = 32'h00000000;
            end
         end
         // the fourth code of the state word is unused; fall back to idle
         default: begin
            seq_d = SEQ_IDLE;
         end
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CONV; gi++) begin : g_slot
         slot_decode u_dec (
            .slotSel (slots[gi*3 +: 3]),
            .seqRun  (seqRun),
            .seqSlot (slot_q),
            .hwEn1   (hwEn1),
            .hwEn2   (hwEn2),
            .convEn  (enNext[gi])
         );
         // converters 1 and 2 use the fine low range, 3 and 4 the wide one
         volt_expand #(.LOW_RANGE(gi < 2)) u_volt (
            .coarse   (coarses[gi*COARSE_W +: COARSE_W]),
            .fullCode (fulls[gi*CODE_W +: CODE_W]),
            .outUv10  (volts[gi*VOLT_W +: VOLT_W])
         );
      end
   endgenerate

   // bus pipeline: capture write address, read data in the address phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 18'h00000;
         rdData_q <= 32'h00000000;
      end else begin
         wrPend_q <= addrPhase && hwrite && wordAcc && hiZero;
         wrAddr_q <= rdAddr;
         if (addrPhase && !hwrite) begin
            rdData_q <= rdMux;
         end
      end
   end

   // configuration registers; upper half of the bus word is ignored
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         oneTwo_q <= CFG_RESET;
      end else if (wrOneTwo) begin
         oneTwo_q <= hwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         threeFour_q <= CFG_RESET;
      end else if (wrThree) begin
         threeFour_q <= hwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fastMode_q <= 1'b0;
      end else if (wrCtrl) begin
         fastMode_q <= hwdata[1];
      end
   end

   // synchronisers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         hw1Sync_q <= 2'b00;
         hw2Sync_q <= 2'b00;
      end else begin
         hw1Sync_q <= {hw1Sync_q[0], hwEnable1Pin};
         hw2Sync_q <= {hw2Sync_q[0], hwEnable2Pin};
      end
   end

   // sequencer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         seq_q  <= SEQ_IDLE;
         slot_q <= 3'h0;
         cnt_q  <= 32'h00000000;
      end else begin
         seq_q  <= seq_d;
         slot_q <= slot_d;
         cnt_q  <= cnt_d;
      end
   end

   // enables; pin-controlled ones lag their pin by three edges
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         en_q <= 4'h0;
      end else begin
         en_q <= enNext;
      end
   end

   // expanded codes
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         code1_q <= 7'h00;
         code2_q <= 7'h00;
         code3_q <= 7'h00;
         code4_q <= 7'h00;
      end else begin
         code1_q <= full1;
         code2_q <= full2;
         code3_q <= full3;
         code4_q <= full4;
      end
   end

   // flag rather than clamp: software owns the choice of code
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         viol_q <= 1'b0;
      end else begin
         viol_q <= fastMode_q && (full1 > LOW_FAST_MAX);
      end
   end

   assign hrdata            = rdData_q;
   assign hreadyout         = 1'b1;
   assign hresp             = 1'b0;
   assign convEnable        = en_q;
   assign conv1VoltCode     = code1_q;
   assign conv2VoltCode     = code2_q;
   assign conv3VoltCode     = code3_q;
   assign conv4VoltCode     = code4_q;
   assign fastModeViolation = viol_q;
endmodule // converter_startup_config_regs

// >>> hw/slot_decode.sv
`timescale 1ns/1ps
// decodes one converter's slot field into its enable
module slot_decode
   import conv_startup_pkg::*;
(
   // configuration
   input  wire logic [2:0] slotSel,
   // sequencer and hardware enables
   input  wire logic       seqRun,
   input  wire logic [2:0] seqSlot,
   input  wire logic       hwEn1,
   input  wire logic       hwEn2,
   // result
   output logic            convEn
);
   wire isTimed = (slotSel != SLOT_OFF) && (slotSel <= SLOT_LAST);
   wire timedOn = isTimed && seqRun && (seqSlot >= slotSel);
   wire hwOn    = (slotSel == SLOT_HW1) ? hwEn1 :
                  (slotSel == SLOT_HW2) ? hwEn2 : 1'b0;
   assign convEn = timedOn | hwOn;
endmodule // slot_decode

// >>> hw/volt_expand.sv
`timescale 1ns/1ps
// turns a stored coarse field into the full code and an output voltage
module volt_expand
   import conv_startup_pkg::*;
#(
   parameter bit LOW_RANGE = 1'b1
)(
   // stored field
   input  wire logic [4:0]  coarse,
   // expanded results
   output logic      [6:0]  fullCode,
   output logic      [15:0] outUv10
);
   wire [6:0]  code = {coarse, 2'b00};
   wire [15:0] lowV = (code <= LOW_FLOOR_CODE) ? 16'(LOW_MIN_UV10) :
                      (code >= LOW_SAT_CODE) ? 16'(LOW_MAX_UV10) :
                      16'(LOW_MIN_UV10 + (int'(code) - 8) * LOW_STEP_UV10);
   wire [15:0] highV = (code >= HIGH_SAT_CODE) ? 16'(HIGH_MAX_UV10) :
                       16'(HIGH_MIN_UV10 + int'(code) * HIGH_STEP_UV10);
   assign fullCode = code;
   assign outUv10  = LOW_RANGE ? lowV : highV;
endmodule // volt_expand

// >>> inc/conv_startup_pkg.sv
// constants for the converter start-up configuration bank
package conv_startup_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] ONE_TWO_IDX    = 16'h7811;
   localparam logic [15:0] THREE_FOUR_IDX = 16'h7812;
   localparam logic [17:0] ONE_TWO_ADDR    = {ONE_TWO_IDX, 2'b00};
   localparam logic [17:0] THREE_FOUR_ADDR = {THREE_FOUR_IDX, 2'b00};
   // own-chosen control/status registers
   localparam logic [17:0] SEQ_CTRL_ADDR  = 18'h1E100;
   localparam logic [17:0] SEQ_STAT_ADDR  = 18'h1E104;
   // read-only expanded voltages, two converters per word, 0.1 mV units
   localparam logic [17:0] VOLT_LOW_ADDR  = 18'h1E108;
   localparam logic [17:0] VOLT_HIGH_ADDR = 18'h1E10C;
   // field positions
   localparam int HI_SLOT_LSB = 13;
   localparam int HI_VOLT_LSB = 8;
   localparam int LO_SLOT_LSB = 5;
   localparam int LO_VOLT_LSB = 0;
   localparam int SLOT_W      = 3;
   localparam int COARSE_W    = 5;
   localparam int CODE_W      = 7;
   localparam int VOLT_W      = 16;
   localparam int NUM_CONV    = 4;
   // reset values
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // slot codes
   localparam logic [2:0] SLOT_OFF  = 3'h0;
   localparam logic [2:0] SLOT_LAST = 3'h5;
   localparam logic [2:0] SLOT_HW1  = 3'h6;
   localparam logic [2:0] SLOT_HW2  = 3'h7;
   // voltage coding, millivolts scaled by 10 (0.1 mV units)
   localparam int LOW_MIN_UV10  = 6000;
   localparam int LOW_MAX_UV10  = 18000;
   localparam int LOW_STEP_UV10 = 125;
   localparam logic [6:0] LOW_FLOOR_CODE = 7'h08;
   localparam logic [6:0] LOW_SAT_CODE   = 7'h68;
   localparam logic [6:0] LOW_FAST_MAX   = 7'h48;
   localparam int HIGH_MIN_UV10  = 8500;
   localparam int HIGH_MAX_UV10  = 34000;
   localparam int HIGH_STEP_UV10 = 250;
   localparam logic [6:0] HIGH_SAT_CODE  = 7'h66;
   // timeslot length
   localparam int SLOT_TIME_US = 2000;
   localparam int CLK_MHZ      = 20;
   localparam int SLOT_CYCLES  = SLOT_TIME_US * CLK_MHZ;
   localparam int NUM_SLOTS    = 5;
endpackage

// >>> verification/conv_startup_monitor.sv
// port assertions for the converter start-up bank
`timescale 1ns/1ps
module conv_startup_monitor
   import conv_startup_pkg::*;
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       sys_rst,
   // bus answer
   input wire logic       hsel,
   input wire logic       hreadyout,
   input wire logic       hresp,
   // converter outputs
   input wire logic [3:0] convEnable,
   input wire logic [6:0] conv1VoltCode,
   input wire logic [6:0] conv2VoltCode,
   input wire logic [6:0] conv3VoltCode,
   input wire logic [6:0] conv4VoltCode,
   input wire logic       fastModeViolation
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus answer not ready okay");
   property p_c1low; conv1VoltCode[1:0] == 2'h0; endproperty
   a_c1low: assert property (p_c1low) else $error("conv1 code low bits set");
   property p_c2low; conv2VoltCode[1:0] == 2'h0; endproperty
   a_c2low: assert property (p_c2low) else $error("conv2 code low bits set");
   property p_c3low; conv3VoltCode[1:0] == 2'h0; endproperty
   a_c3low: assert property (p_c3low) else $error("conv3 code low bits set");
   property p_c4low; conv4VoltCode[1:0] == 2'h0; endproperty
   a_c4low: assert property (p_c4low) else $error("conv4 code low bits set");
   property p_rst; $fell(sys_rst) |-> convEnable == 4'h0 && conv1VoltCode == 7'h0; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   // conv3 and conv4 codes move only as a consequence of a bus write
   property p_hold; !$past(hsel) && !$past(hsel, 2) && !$past(hsel, 3)
      |-> $stable(conv3VoltCode) && $stable(conv4VoltCode); endproperty
   a_hold: assert property (p_hold) else $error("code changed without access");
   property p_viol; fastModeViolation |-> conv1VoltCode > LOW_FAST_MAX; endproperty
   a_viol: assert property (p_viol) else $error("violation flag without high code");
endmodule // conv_startup_monitor

bind converter_startup_config_regs conv_startup_monitor u_mon (
   .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .hreadyout(hreadyout), .hresp(hresp),
   .convEnable(convEnable), .conv1VoltCode(conv1VoltCode), .conv2VoltCode(conv2VoltCode),
   .conv3VoltCode(conv3VoltCode), .conv4VoltCode(conv4VoltCode),
   .fastModeViolation(fastModeViolation));

// >>> verification/tb_converter_startup_config_regs.sv
// self-checking bench for the converter start-up bank
`timescale 1ns/1ps
module tb_converter_startup_config_regs import conv_startup_pkg::*;;
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        hwEnable1Pin = 1'b0;
   logic        hwEnable2Pin = 1'b0;
   logic [3:0]  convEnable;
   logic [6:0]  conv1VoltCode, conv2VoltCode, conv3VoltCode, conv4VoltCode;
   logic        fastModeViolation;
   logic [31:0] rd, a, lo, hi;
   int          miscompares = 0;
   int          check_count = 0;
   int          n;
   localparam logic [31:0] R12 = {14'h0, ONE_TWO_ADDR};
   localparam logic [31:0] R34 = {14'h0, THREE_FOUR_ADDR};
   // upper half of the first row is junk that must not stick
   logic [31:0] rowData [4] = '{32'hFFFF_1F1F, 32'h0000_0102, 32'h0000_1A01, 32'h0000_0110};
   // expected codes {upper, lower converter of the pair}, voltages in 0.1 mV
   logic [15:0] rowCode [4] = '{16'h7C7C, 16'h0408, 16'h6804, 16'h0440};
   logic [31:0] rowVolt [4] = '{32'h4650_4650, 32'h1770_1770, 32'h84D0_251C, 32'h251C_5FB4};
   localparam logic [31:0] VLO = {14'h0, VOLT_LOW_ADDR};
   localparam logic [31:0] VHI = {14'h0, VOLT_HIGH_ADDR};
   assign hready = hreadyout;
   converter_startup_config_regs #(.SLOT_LEN(4)) u_dut (
      .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .hwEnable1Pin(hwEnable1Pin),
      .hwEnable2Pin(hwEnable2Pin), .convEnable(convEnable), .conv1VoltCode(conv1VoltCode),
      .conv2VoltCode(conv2VoltCode), .conv3VoltCode(conv3VoltCode),
      .conv4VoltCode(conv4VoltCode), .fastModeViolation(fastModeViolation));
   initial forever #25 mclk = ~mclk;
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic limit(input int cnt, input int most);
      if (cnt >= most) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic waitRdy();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      limit(k, 50);
   endtask
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= ad;
      waitRdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rd = hrdata;
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int r = 0; r < 2; r++) begin
         bus(1'b0, r ? R34 : R12, 32'h0);
         chk(rd, {16'h0, CFG_RESET});
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         a = (i < 2) ? R12 : R34;
         bus(1'b1, a, rowData[i]);
         settle();
         lo = {25'h0, (i < 2) ? conv1VoltCode : conv3VoltCode};
         hi = {25'h0, (i < 2) ? conv2VoltCode : conv4VoltCode};
         chk(lo, {25'h0, rowCode[i][6:0]});
         chk(hi, {25'h0, rowCode[i][14:8]});
         bus(1'b0, a, 32'h0);
         chk(rd, {16'h0, rowData[i][15:0]});
         bus(1'b0, (i < 2) ? VLO : VHI, 32'h0);
         chk(rd, rowVolt[i]);
      end
      $display("test field rows done");
      // conv2 on the first pin, conv1 on the second
      bus(1'b1, R12, 32'h0000_C0E0);
      for (int i = 0; i < 4; i++) begin
         hwEnable1Pin <= i[0];
         hwEnable2Pin <= i[1];
         repeat (6) @(posedge mclk);
         chk({28'h0, convEnable}, {30'h0, i[0], i[1]});
      end
      hwEnable1Pin <= 1'b0;
      hwEnable2Pin <= 1'b0;
      $display("test hardware enables done");
      bus(1'b1, R12, 32'h0000_A020);
      bus(1'b1, R34, 32'h0000_6000);
      bus(1'b1, {14'h0, SEQ_CTRL_ADDR}, 32'h1);
      n = 0;
      while (convEnable[0] !== 1'b1 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      limit(n, 500);
      #1;
      chk({28'h0, convEnable}, 32'h1);
      n = 0;
      do begin
         bus(1'b0, {14'h0, SEQ_STAT_ADDR}, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 100);
      limit(n, 100);
      settle();
      chk({28'h0, convEnable}, 32'hB);
      $display("test timeslots done");
      bus(1'b1, {14'h0, SEQ_CTRL_ADDR}, 32'h2);
      bus(1'b1, R12, 32'h0000_0013);
      settle();
      chk({31'h0, fastModeViolation}, 32'h1);
      bus(1'b0, VLO, 32'h0);
      chk(rd, 32'h1770_38A4);
      bus(1'b1, R12, 32'h0000_0012);
      settle();
      chk({31'h0, fastModeViolation}, 32'h0);
      chk({25'h0, conv1VoltCode}, {25'h0, LOW_FAST_MAX});
      bus(1'b0, VLO, 32'h0);
      chk(rd, 32'h1770_36B0);
      // unmapped write must leave the bank alone
      bus(1'b1, 32'h0001_0000, 32'h0000_FFFF);
      bus(1'b0, 32'h0001_0000, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, R12, 32'h0);
      chk(rd, 32'h0000_0012);
      $display("test fast mode and unmapped done");
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      bus(1'b0, R34, 32'h0);
      chk(rd, 32'h0);
      chk({25'h0, conv4VoltCode}, 32'h0);
      chk({28'h0, convEnable}, 32'h0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule // tb_converter_startup_config_regs
